// ### hw/ext_irq_edge_ctrl.sv
// external pin interrupt controller: seven maskable inputs and one
// pin shared between the non-maskable interrupt and cpu level 13.
// assumes an Avalon-MM master on i_ref_clk and asynchronous pins;
// the timer 1 request comes from logic on the same clock.
`timescale 1ns/10ps
`include "ext_irq_consts.svh"

// What this block does
// - seven maskable pin interrupts, each with an identically laid out control.
// - one shared pin feeds either the non-maskable interrupt or level 13.
// - every input has software edge choice and enable, which gates all but the shared pin's level 13 route.
// - each maskable input has a 16-bit counter cleared by a valid edge.
// - polarity bits 3-2: 00 falling edge, 01 rising edge.
// - polarity 10 acts as falling; 11 fires on both edges.
// - bit 0 is the read/write enable; 1 enables, 0 disables.
// - bits 15-4, and bit 1 of maskable controls, read zero, ignore writes.
// - non-maskable control bit 1 picks level 13 source: 0 timer, 1 pin.
// - non-maskable control shares polarity bits 3-2 and enable bit 0.
// - counters tick each clock, wrap at maximum, stop while disabled.
// - counters are read-only; only a valid edge or reset clears them.
// - pin drives non-maskable only with enable 1, select 0.
// - non-maskable counter runs while enabled, whatever select says.
module ext_irq_edge_ctrl (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // avalon-mm register slave, byte addressed
   input wire logic [17:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // external pins and timer request
   input wire logic [6:0] i_ext_irq_pin,
   input wire logic i_shared_nmi_level13_pin,
   input wire logic i_timer1_irq,
   // cpu interrupt requests
   output logic [6:0] o_ext_irq,
   output logic o_ext_nonmaskable_irq,
   output logic o_cpu_level_13,
   // summary interrupt
   output logic o_irq
);

   function automatic logic addr_hit(input logic [17:0] addr,
                                     input logic [15:0] idx);
      addr_hit = (addr[17:2] == idx);
   endfunction

   function automatic logic [31:0] ctrl_word(
      input ext_irq_pkg::ctrl_type c);
      ctrl_word = {28'h000_0000, c.polarity, c.select, c.enable};
   endfunction

   // control registers; entry 7 belongs to the shared pin
   ext_irq_pkg::ctrl_type ctrl_r [0:7];
   ext_irq_pkg::chan_obs_type obs [0:7];
   logic [7:0] pins;
   logic [7:0] count_run;

   // bus handshake state
   logic ack_r;
   logic req;
   logic taken;
   logic wr_taken;
   logic rd_taken;
   logic [31:0] readdata_r;
   logic [31:0] read_value;

   // event and status plumbing
   logic [7:0] events;
   logic [7:0] status;
   logic [7:0] mask;
   logic status_clear;
   logic mask_write;

   // registered cpu requests
   logic [6:0] ext_irq_r;
   logic nmi_r;
   logic level13_r;

   assign pins = {i_shared_nmi_level13_pin, i_ext_irq_pin};

   // ------------------------------------------------------------
   // avalon slave: one wait cycle, then answer; write lands then
   // ------------------------------------------------------------
   assign req = i_avs_read | i_avs_write;
   assign taken = req & ack_r;
   assign wr_taken = i_avs_write & ack_r;
   assign rd_taken = i_avs_read & ack_r;
   assign o_avs_waitrequest = req & ~ack_r;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         ack_r <= 1'b0;
      else if (taken)
         ack_r <= 1'b0;
      else
         ack_r <= req;
   end

   // data is captured in the wait cycle so it is a flop output
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         readdata_r <= 32'h0000_0000;
      else if (i_avs_read & ~ack_r)
         readdata_r <= read_value;
   end

   assign o_avs_readdata = readdata_r;

   // read decode; unmapped and reserved bits read zero
   always_comb
   begin
      read_value = 32'h0000_0000;
      for (int i = 0; i < `EXT_CHANNELS; i++)
      begin
         if (addr_hit(i_avs_address, `EXT_CTRL_FIRST_IDX + 16'(i)))
            read_value = ctrl_word(ctrl_r[i]);
         if (addr_hit(i_avs_address, `EXT_CNT_FIRST_IDX + 16'(i)))
            read_value = {16'h0000, obs[i].count};
      end
      if (addr_hit(i_avs_address, `NMI_CTRL_IDX))
         read_value = ctrl_word(ctrl_r[`NMI_CHANNEL]);
      if (addr_hit(i_avs_address, `NMI_CNT_IDX))
         read_value = {16'h0000, obs[`NMI_CHANNEL].count};
      if (addr_hit(i_avs_address, `IRQ_STATUS_IDX))
         read_value = {24'h00_0000, status};
      if (addr_hit(i_avs_address, `IRQ_MASK_IDX))
         read_value = {24'h00_0000, mask};
   end

   // ------------------------------------------------------------
   // control registers; only the low byte holds live bits
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < `ALL_CHANNELS; i++)
            ctrl_r[i] <= '0;
      end
      else if (wr_taken & i_avs_byteenable[0])
      begin
         for (int i = 0; i < `EXT_CHANNELS; i++)
         begin
            if (addr_hit(i_avs_address, `EXT_CTRL_FIRST_IDX + 16'(i)))
            begin
               ctrl_r[i].polarity <=
                  i_avs_writedata[`CTRL_POL_HI:`CTRL_POL_LO];
               ctrl_r[i].enable <=
                  i_avs_writedata[`CTRL_ENABLE_BIT];
               ctrl_r[i].select <= 1'b0;
            end
         end
         if (addr_hit(i_avs_address, `NMI_CTRL_IDX))
         begin
            ctrl_r[`NMI_CHANNEL].polarity <=
               i_avs_writedata[`CTRL_POL_HI:`CTRL_POL_LO];
            ctrl_r[`NMI_CHANNEL].enable <=
               i_avs_writedata[`CTRL_ENABLE_BIT];
            ctrl_r[`NMI_CHANNEL].select <=
               i_avs_writedata[`CTRL_SELECT_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // pin channels; counters never take bus writes
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `ALL_CHANNELS; g++)
      begin : gen_chan
         // enable alone gates each counter, select plays no part
         assign count_run[g] = ctrl_r[g].enable;

         edge_channel u_chan (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_pin(pins[g]),
            .i_count_run(count_run[g]),
            .i_ctrl(ctrl_r[g]),
            .o_obs(obs[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // routing to the cpu, registered one-cycle pulses
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         ext_irq_r <= 7'h00;
      else
      begin
         for (int i = 0; i < `EXT_CHANNELS; i++)
            ext_irq_r[i] <= obs[i].edge_seen & ctrl_r[i].enable;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         nmi_r <= 1'b0;
      else
         nmi_r <= obs[`NMI_CHANNEL].edge_seen
            & ctrl_r[`NMI_CHANNEL].enable
            & ~ctrl_r[`NMI_CHANNEL].select;
   end

   // pin reaches level 13 on select alone, enable does not gate it
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         level13_r <= 1'b0;
      else if (ctrl_r[`NMI_CHANNEL].select)
         level13_r <= obs[`NMI_CHANNEL].edge_seen;
      else
         level13_r <= i_timer1_irq;
   end

   assign o_ext_irq = ext_irq_r;
   assign o_ext_nonmaskable_irq = nmi_r;
   assign o_cpu_level_13 = level13_r;

   // ------------------------------------------------------------
   // sticky status: bits 6..0 maskable edges, bit 7 shared pin
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < `ALL_CHANNELS; i++)
         events[i] = obs[i].edge_seen & ctrl_r[i].enable;
   end

   // clear at the capture edge, so only the bits reported are dropped
   assign status_clear = i_avs_read & ~ack_r
      & addr_hit(i_avs_address, `IRQ_STATUS_IDX);
   assign mask_write = wr_taken & i_avs_byteenable[0]
      & addr_hit(i_avs_address, `IRQ_MASK_IDX);

   irq_status u_status (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_event(events),
      .i_read_clear(status_clear),
      .i_mask_write(mask_write),
      .i_mask_data(i_avs_writedata[7:0]),
      .o_status(status),
      .o_mask(mask),
      .o_irq(o_irq)
   );

endmodule // ext_irq_edge_ctrl

// ### hw/ext_irq_consts.svh
// register indices, field positions and reset values of the
// external interrupt edge controller; assumes 32-bit Avalon words
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

// register indices; byte address is four times the index
`define EXT_CTRL_FIRST_IDX 16'h7070
`define NMI_CTRL_IDX 16'h7077
`define EXT_CNT_FIRST_IDX 16'h7078
`define NMI_CNT_IDX 16'h707F
`define IRQ_STATUS_IDX 16'h7080
`define IRQ_MASK_IDX 16'h7081

// field positions of the control registers
`define CTRL_ENABLE_BIT 0
`define CTRL_SELECT_BIT 1
`define CTRL_POL_LO 2
`define CTRL_POL_HI 3

// polarity codes
`define POL_FALL 2'h0
`define POL_RISE 2'h1
`define POL_FALL_ALT 2'h2
`define POL_BOTH 2'h3

// counts and reset values
`define EXT_CHANNELS 7
`define ALL_CHANNELS 8
`define NMI_CHANNEL 7
`define CNT_WIDTH 16
`define CNT_RESET 16'h0000
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00

`endif

// ### hw/ext_irq_pkg.sv
// types shared by the external interrupt edge controller files
package ext_irq_pkg;

   // one control register, unpacked into its live fields
   typedef struct packed {
      logic [1:0] polarity;
      logic select;
      logic enable;
   } ctrl_type;

   // one channel's observation
   typedef struct packed {
      logic edge_seen;
      logic [15:0] count;
   } chan_obs_type;

endpackage

// ### hw/edge_channel.sv
// one pin channel: synchroniser, edge detector, timestamp counter
// assumes the pin is asynchronous to i_ref_clk
`timescale 1ns/10ps
`include "ext_irq_consts.svh"

module edge_channel (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // pin and control
   input wire logic i_pin,
   input wire logic i_count_run,
   input wire ext_irq_pkg::ctrl_type i_ctrl,
   // observation
   output ext_irq_pkg::chan_obs_type o_obs
);

   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic rise;
   logic fall;
   logic hit;
   logic [15:0] count_r;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         sync1_r <= i_pin;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign rise = sync2_r & ~prev_r;
   assign fall = ~sync2_r & prev_r;

   always_comb
   begin
      case (i_ctrl.polarity)
         `POL_RISE: hit = rise;
         `POL_BOTH: hit = rise | fall;
         default: hit = fall; // codes 00 and 10
      endcase
   end

   // counter frozen while disabled; edge clears it
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         count_r <= `CNT_RESET;
      else if (i_count_run)
      begin
         if (hit)
            count_r <= `CNT_RESET;
         else
            count_r <= count_r + 16'h0001; // wraps
      end
   end

   assign o_obs.edge_seen = hit;
   assign o_obs.count = count_r;

endmodule // edge_channel

// ### hw/irq_status.sv
// sticky event status, mask and level interrupt output
// assumes events are one-cycle pulses on i_ref_clk
`timescale 1ns/10ps
`include "ext_irq_consts.svh"

module irq_status (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // events and software access
   input wire logic [7:0] i_event,
   input wire logic i_read_clear,
   input wire logic i_mask_write,
   input wire logic [7:0] i_mask_data,
   // state
   output logic [7:0] o_status,
   output logic [7:0] o_mask,
   output logic o_irq
);

   logic [7:0] status_r;
   logic [7:0] mask_r;
   logic irq_r;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         status_r <= `STATUS_RESET;
      else if (i_read_clear)
         status_r <= i_event;
      else
         status_r <= status_r | i_event;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         mask_r <= `MASK_RESET;
      else if (i_mask_write)
         mask_r <= i_mask_data;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         irq_r <= 1'b0;
      else
         irq_r <= |((i_read_clear ? i_event : (status_r | i_event))
            & (i_mask_write ? i_mask_data : mask_r));
   end

   assign o_status = status_r;
   assign o_mask = mask_r;
   assign o_irq = irq_r;

endmodule // irq_status

// ### testbench/ext_irq_edge_ctrl_checker.sv
// port-level checks of the external pin interrupt controller
// assumes one clock; control bits are shadowed from bus writes
`timescale 1ns/10ps
module ext_irq_edge_ctrl_checker (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // register bus
   input wire logic [17:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // requests
   input wire logic i_timer1_irq,
   input wire logic [6:0] o_ext_irq,
   input wire logic o_ext_nonmaskable_irq,
   input wire logic o_cpu_level_13
);
   logic [15:0] idx;
   logic [3:0] nctl_r;
   logic ctl0_r;
   assign idx = i_avs_address[17:2];
   // shadow copies let the checks see control without a bus read
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         nctl_r <= 4'h0;
         ctl0_r <= 1'b0;
      end
      else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0])
      begin
         if (idx == 16'h7077)
            nctl_r <= i_avs_writedata[3:0];
         if (idx == 16'h7070)
            ctl0_r <= i_avs_writedata[0];
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence rd_done;
      i_avs_read && !o_avs_waitrequest;
   endsequence
   sequence ctl_rd;
      rd_done ##0 (idx >= 16'h7070 && idx <= 16'h7077);
   endsequence
   rsv_zero_a: assert property (ctl_rd |-> o_avs_readdata[31:4] == 0)
      else $error("reserved control bits not zero");
   sel_zero_a: assert property ((ctl_rd ##0 idx != 16'h7077)
      |-> !o_avs_readdata[1]) else $error("bit 1 of control not zero");
   nmi_back_a: assert property ((rd_done ##0 idx == 16'h7077)
      |-> o_avs_readdata[3:0] == nctl_r) else $error("shared control lost");
   ctl_back_a: assert property ((rd_done ##0 idx == 16'h7070)
      |-> o_avs_readdata[0] == ctl0_r) else $error("enable readback wrong");
   pulse_one_a: assert property ((o_ext_irq & $past(o_ext_irq)) == 0)
      else $error("request pulse longer than one cycle");
   en_gate_a: assert property (o_ext_irq[0] |-> $past(ctl0_r))
      else $error("request while disabled");
   nmi_gate_a: assert property (o_ext_nonmaskable_irq
      |-> ($past(nctl_r) & 4'h3) == 4'h1)
      else $error("non-maskable request not gated");
   l13_timer_a: assert property (!$past(i_rst) && !$past(nctl_r[1])
      |-> o_cpu_level_13 == $past(i_timer1_irq))
      else $error("level 13 not from timer");
endmodule // ext_irq_edge_ctrl_checker

bind ext_irq_edge_ctrl ext_irq_edge_ctrl_checker chk_u (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_timer1_irq(i_timer1_irq), .o_ext_irq(o_ext_irq),
   .o_ext_nonmaskable_irq(o_ext_nonmaskable_irq),
   .o_cpu_level_13(o_cpu_level_13));

// ### testbench/cpu_pin_model.sv
// far side: pin drivers, timer 1 source and cpu request tallies
// assumes i_clr is held while the controller is in reset
`timescale 1ns/10ps
module cpu_pin_model (
   // clock and bench control
   input wire logic i_ref_clk,
   input wire logic i_clr,
   input wire logic [7:0] i_level,
   input wire logic i_timer_on,
   // pins
   output logic [6:0] o_pin,
   output logic o_shared,
   output logic o_timer1,
   // cpu side
   input wire logic [6:0] i_ext_irq,
   input wire logic i_nmi,
   input wire logic i_l13,
   output logic [6:0] o_seen,
   output logic [7:0] o_n0,
   output logic [7:0] o_nmi,
   output logic [7:0] o_l13
);
   logic [5:0] tick_r;
   always_ff @(posedge i_ref_clk)
   begin
      // pins move only after an edge, like a clean external source
      {o_shared, o_pin} <= i_level;
      tick_r <= tick_r + 6'h01;
      o_timer1 <= i_timer_on && tick_r == 6'h3F;
      o_seen <= o_seen | i_ext_irq;
      o_n0 <= o_n0 + {7'h00, i_ext_irq[0]};
      o_nmi <= o_nmi + {7'h00, i_nmi};
      o_l13 <= o_l13 + {7'h00, i_l13};
      if (i_clr)
      begin
         tick_r <= 6'h00;
         o_seen <= 7'h00;
         o_n0 <= 8'h00;
         o_nmi <= 8'h00;
         o_l13 <= 8'h00;
      end
   end
endmodule // cpu_pin_model

// ### testbench/testbench.sv
// self-checking bench of the external pin interrupt controller
// assumes the pin model and the bound checker are compiled first
`timescale 1ns/10ps
module testbench;
   logic clk, rst, rd, wr, wrq, ton, clr, sh, t1, nmi, l13, irq;
   logic [17:0] addr;
   logic [31:0] wd, rdat, q, a;
   logic [7:0] lvl, n0, nn, nl, c;
   logic [6:0] pin, eirq, seen;
   int err_total, checks_done, cyc;
   ext_irq_edge_ctrl dut_u (.i_ref_clk(clk), .i_rst(rst),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
      .i_ext_irq_pin(pin), .i_shared_nmi_level13_pin(sh),
      .i_timer1_irq(t1), .o_ext_irq(eirq), .o_ext_nonmaskable_irq(nmi),
      .o_cpu_level_13(l13), .o_irq(irq));
   cpu_pin_model far_u (.i_ref_clk(clk), .i_clr(clr), .i_level(lvl),
      .i_timer_on(ton), .o_pin(pin), .o_shared(sh), .o_timer1(t1),
      .i_ext_irq(eirq), .i_nmi(nmi), .i_l13(l13), .o_seen(seen),
      .o_n0(n0), .o_nmi(nn), .o_l13(nl));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic conclude;
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one bus transfer; the idle edge after it keeps drivers single
   task automatic acc(input logic w, input logic [15:0] i,
                      input logic [31:0] d);
      addr <= {i, 2'b00};
      wd <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wrq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input string nm, input logic [15:0] i,
                     input logic [31:0] e);
      acc(1'b0, i, 32'h0000_0000);
      chk(nm, q, e);
   endtask
   task automatic pn(input logic [7:0] v);
      lvl <= v;
      repeat (6) @(posedge clk);
   endtask
   initial
   begin
      {rst, clr, rd, wr, ton, addr, wd, lvl} = {2'b11, 3'b000, 18'h0, 32'h0, 8'h0};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      clr <= 1'b0;
      rc("ctl0 reset", 16'h7070, 32'h0000_0000);
      rc("nmi ctl reset", 16'h7077, 32'h0000_0000);
      rc("cnt0 reset", 16'h7078, 32'h0000_0000);
      acc(1'b1, 16'h7070, 32'hFFFF_FFFF);
      rc("ctl0 fields", 16'h7070, 32'h0000_000D);
      acc(1'b1, 16'h7077, 32'hFFFF_FFFF);
      rc("nmi fields", 16'h7077, 32'h0000_000F);
      acc(1'b1, 16'h7079, 32'h0000_1234);
      rc("cnt1 held", 16'h7079, 32'h0000_0000);
      for (int p = 0; p < 4; p++)
      begin
         acc(1'b1, 16'h7070, {28'h0, p[1:0], 2'b01});
         c = n0;
         pn(8'h01);
         chk("rise", n0 - c, p == 1 || p == 3);
         c = n0;
         pn(8'h00);
         chk("fall", n0 - c, p != 1);
      end
      acc(1'b0, 16'h7078, 32'h0000_0000);
      a = q;
      chk("fresh count", a < 32'h0000_0010, 1);
      acc(1'b0, 16'h7078, 32'h0000_0000);
      chk("count step", q - a, 3);
      acc(1'b1, 16'h7070, 32'h0000_0000);
      acc(1'b0, 16'h7078, 32'h0000_0000);
      a = q;
      c = n0;
      pn(8'h01);
      pn(8'h00);
      chk("disabled", n0 - c, 0);
      rc("stopped", 16'h7078, a);
      for (int i = 0; i < 7; i++)
         acc(1'b1, 16'h7070 + i[15:0], 32'h0000_0005);
      acc(1'b1, 16'h7081, 32'h0000_0001);
      pn(8'h7F);
      chk("all seven", seen, 7'h7F);
      @(negedge clk);
      chk("irq set", irq, 1);
      @(posedge clk);
      rc("status", 16'h7080, 32'h0000_007F);
      @(negedge clk);
      chk("irq clear", irq, 0);
      @(posedge clk);
      acc(1'b1, 16'h7077, 32'h0000_0005);
      c = nl;
      pn(8'h80);
      chk("nmi", nn, 1);
      chk("l13 quiet", nl, c);
      acc(1'b1, 16'h7077, 32'h0000_0007);
      pn(8'h00);
      pn(8'h80);
      chk("nmi off", nn, 1);
      chk("l13 pin", nl - c, 1);
      acc(1'b0, 16'h707F, 32'h0000_0000);
      a = q;
      rc("nmi count", 16'h707F, a + 3);
      acc(1'b1, 16'h7077, 32'h0000_0002);
      acc(1'b0, 16'h707F, 32'h0000_0000);
      a = q;
      rc("nmi count off", 16'h707F, a);
      acc(1'b1, 16'h7077, 32'h0000_0000);
      c = nl;
      ton <= 1'b1;
      repeat (140) @(posedge clk);
      ton <= 1'b0;
      chk("timer", nl != c, 1);
      conclude();
   end
endmodule // testbench
